/* design/dsc_pkg.sv */
// Constants and types for the debug serial command port
`default_nettype none
package dsc_pkg;
    localparam int          XFER_BITS      = 17;
    localparam logic [4:0]  BIT_CNT_INIT   = 5'h11;
    localparam logic [16:0] RESP_NOT_READY = 17'h1_0000;
    localparam logic [16:0] RESP_BUS_ERR   = 17'h1_0001;
    localparam logic [16:0] RESP_ILLEGAL   = 17'h1_FFFF;
    localparam logic [16:0] RESP_COMPLETE  = 17'h0_FFFF;

    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_RX        = 8'h08;
    localparam logic [7:0]  ADDR_RESP      = 8'h0C;
    localparam logic [7:0]  ADDR_CMD       = 8'h10;
    localparam logic        CTRL_RESET     = 1'h1;

    localparam logic [1:0]  KIND_DATA      = 2'h0;
    localparam logic [1:0]  KIND_COMPLETE  = 2'h1;
    localparam logic [1:0]  KIND_BUS_ERR   = 2'h2;
    localparam logic [1:0]  KIND_ILLEGAL   = 2'h3;

    localparam logic [1:0]  SIZE_BYTE      = 2'h0;
    localparam logic [1:0]  SIZE_WORD      = 2'h1;
    localparam logic [1:0]  SIZE_LONG      = 2'h2;
    localparam logic [1:0]  SIZE_RSVD      = 2'h3;

    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_STEP = 2'b10
    } dsc_state_t;

    typedef struct packed {
        logic [5:0] opcode;
        logic       zero9;
        logic       dir_read;
        logic [1:0] size;
        logic [1:0] zero54;
        logic       addr_class;
        logic [2:0] regnum;
    } dsc_cmd_t;
endpackage
`default_nettype wire

/* design/dsc_port.sv */
// Debug serial command port with APB register access for the core side
//
// Behaviour
// [R1] Status clear: valid data; FFFF means complete
// [R2] Not ready: status set, data 0000
// [R3] Bus error 0001, illegal FFFF, status set
// [R4] Serial clock and input pass two flops
// [R5] Synced rising edge: shift in, decrement count
// [R6] Output shifter advances right after edge
// [R7] Count zero: latch word, preload not ready
// [R8] Latched word releases core; core overwrites response
// [R9] Written response drives serial output at once; here it is held until a running transfer ends and the clock stands high
// [R10] Master may start on output change, timeout
// [R11] Response load never disturbs running transfer
// [R12] Master requests breakpoint by driving request low; this port does not detect it
// [R13] Master leaves serial clock high after transfer
// [R14] Clock idles high, pulses low per bit
// [R15] Forced entry held in latch until clock; this port has no such latch
// [R16] Command fields: opcode, direction, size, class, register
// [R17] Direction one means device to master
// [R18] Size 00 byte, 01 word, 10 long
// [R19] Class bit one selects address register
// [R20] Extension words follow, most significant first
// [R21] Command transfer returns previous command's last result
// [R22] Next transfer returns not ready or illegal
// [R23] Each transfer is seventeen bits
// [R24] MSB first, changed after fall, latched rising
// [R25] Master sends status bit clear, ignored here
`default_nettype none
module dsc_port (
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        DEBUG_SERIAL_CLOCK_I,
    input  wire logic        DEBUG_SERIAL_IN_I,
    output logic             DEBUG_SERIAL_OUT_O,
    output logic             WORD_READY_O
);
    logic                clk_s1;
    logic                clk_s2;
    logic                clk_s3;
    logic                din_s1;
    logic                din_s2;
    logic                rise;
    dsc_pkg::dsc_state_t state;
    dsc_pkg::dsc_state_t next_state;
    logic [4:0]          bit_cnt;
    logic [4:0]          next_bit_cnt;
    logic [16:0]         in_sr;
    logic [16:0]         next_in_sr;
    logic [16:0]         out_sr;
    logic [16:0]         next_out_sr;
    logic [16:0]         rx_word;
    logic [16:0]         next_rx_word;
    logic                rx_valid;
    logic                next_rx_valid;
    logic [16:0]         pend_resp;
    logic [16:0]         next_pend_resp;
    logic                pend_valid;
    logic                next_pend_valid;
    logic                enable;
    logic                next_enable;
    logic                apply;
    logic                apb_wr;
    logic                apb_rd_rx;
    logic                apb_setup;
    logic [31:0]         rdata;
    logic [31:0]         next_rdata;
    logic                slverr;
    logic                next_slverr;
    logic [16:0]         wr_resp;
    dsc_pkg::dsc_cmd_t   cmd;
    logic                fmt_err;
    logic [1:0]          operand_words;

    // Synchronisers; first stage feeds only the second
    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            clk_s1 <= 1'b1;
            clk_s2 <= 1'b1;
            clk_s3 <= 1'b1;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end
        else
        begin
            clk_s1 <= DEBUG_SERIAL_CLOCK_I; // [R4]
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            din_s1 <= DEBUG_SERIAL_IN_I; // [R4]
            din_s2 <= din_s1;
        end
    end

    assign rise = clk_s2 & ~clk_s3; // [R24]

    assign apb_setup = PSEL_I & ~PENABLE_I;
    assign apb_wr    = PSEL_I & PENABLE_I & PWRITE_I;
    assign apb_rd_rx = PSEL_I & PENABLE_I & ~PWRITE_I & (PADDR_I == dsc_pkg::ADDR_RX);

    // Canned responses spare software from building status codes
    always_comb
    begin
        case (PWDATA_I[1:0])
            dsc_pkg::KIND_DATA:     wr_resp = {1'b0, PWDATA_I[31:16]}; // [R1]
            dsc_pkg::KIND_COMPLETE: wr_resp = dsc_pkg::RESP_COMPLETE; // [R1]
            dsc_pkg::KIND_BUS_ERR:  wr_resp = dsc_pkg::RESP_BUS_ERR; // [R3]
            dsc_pkg::KIND_ILLEGAL:  wr_resp = dsc_pkg::RESP_ILLEGAL; // [R3]
            default:                wr_resp = dsc_pkg::RESP_NOT_READY;
        endcase
    end

    // Response only lands while the clock has stood high, never mid-shift;
    // a pin rise still in the synchroniser would otherwise split bit 16
    assign apply = pend_valid && (state == dsc_pkg::ST_WAIT)
                   && (bit_cnt == dsc_pkg::BIT_CNT_INIT) && clk_s2 && clk_s3; // [R11]

    always_comb
    begin
        next_state      = state;
        next_bit_cnt    = bit_cnt;
        next_in_sr      = in_sr;
        next_out_sr     = out_sr;
        next_rx_word    = rx_word;
        next_rx_valid   = rx_valid;
        next_pend_resp  = pend_resp;
        next_pend_valid = pend_valid;
        next_enable     = enable;
        if (apb_rd_rx)
            next_rx_valid = 1'b0;
        if (apply)
        begin
            next_out_sr     = pend_resp; // [R9] [R21]
            next_pend_valid = 1'b0;
        end
        if (apb_wr && PADDR_I == dsc_pkg::ADDR_RESP)
        begin
            next_pend_resp  = wr_resp; // [R8]
            next_pend_valid = 1'b1;
        end
        if (apb_wr && PADDR_I == dsc_pkg::ADDR_CTRL)
            next_enable = PWDATA_I[0];
        case (state)
            dsc_pkg::ST_WAIT:
            begin
                if (!enable)
                    next_bit_cnt = dsc_pkg::BIT_CNT_INIT;
                else if (rise)
                begin
                    next_in_sr   = {in_sr[15:0], din_s2}; // [R5] [R24]
                    next_bit_cnt = bit_cnt - 5'h1; // [R5] [R23]
                    next_state   = dsc_pkg::ST_STEP;
                end
            end
            dsc_pkg::ST_STEP:
            begin
                next_out_sr = {out_sr[15:0], 1'b0}; // [R6]
                if (bit_cnt == 5'h0)
                begin
                    next_rx_word  = in_sr; // [R7]
                    next_rx_valid = 1'b1; // [R8]
                    next_out_sr   = dsc_pkg::RESP_NOT_READY; // [R2] [R7] [R22]
                    next_bit_cnt  = dsc_pkg::BIT_CNT_INIT; // [R23]
                end
                next_state = dsc_pkg::ST_WAIT;
            end
            default:
            begin
                next_state   = dsc_pkg::ST_WAIT;
                next_bit_cnt = dsc_pkg::BIT_CNT_INIT;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            state      <= dsc_pkg::ST_WAIT;
            bit_cnt    <= dsc_pkg::BIT_CNT_INIT;
            in_sr      <= 17'h0_0000;
            out_sr     <= dsc_pkg::RESP_NOT_READY;
            rx_word    <= 17'h0_0000;
            rx_valid   <= 1'b0;
            pend_resp  <= 17'h0_0000;
            pend_valid <= 1'b0;
            enable     <= dsc_pkg::CTRL_RESET;
        end
        else
        begin
            state      <= next_state;
            bit_cnt    <= next_bit_cnt;
            in_sr      <= next_in_sr;
            out_sr     <= next_out_sr;
            rx_word    <= next_rx_word;
            rx_valid   <= next_rx_valid;
            pend_resp  <= next_pend_resp;
            pend_valid <= next_pend_valid;
            enable     <= next_enable;
        end
    end

    // Decode of the last word; status/control bit is not looked at
    assign cmd     = dsc_pkg::dsc_cmd_t'(rx_word[15:0]); // [R16] [R25]
    assign fmt_err = cmd.zero9 | (|cmd.zero54) | (cmd.size == dsc_pkg::SIZE_RSVD); // [R16] [R18]
    assign operand_words = (cmd.size == dsc_pkg::SIZE_LONG) ? 2'h2 : 2'h1; // [R20]

    always_comb
    begin
        next_rdata  = rdata;
        next_slverr = 1'b0;
        if (apb_setup)
        begin
            next_rdata = 32'h0000_0000;
            case (PADDR_I)
                dsc_pkg::ADDR_CTRL:   next_rdata[0] = enable;
                dsc_pkg::ADDR_STATUS: next_rdata[8:0] = {bit_cnt, 1'b0, pend_valid,
                                                         (bit_cnt != dsc_pkg::BIT_CNT_INIT),
                                                         rx_valid};
                dsc_pkg::ADDR_RX:     next_rdata[16:0] = rx_word;
                dsc_pkg::ADDR_RESP:   next_rdata[16:0] = pend_resp;
                dsc_pkg::ADDR_CMD:    next_rdata[18:0] = {operand_words, fmt_err,
                                                          cmd.regnum, cmd.addr_class, // [R19]
                                                          1'b0, cmd.size, cmd.dir_read, // [R17]
                                                          2'h0, cmd.opcode};
                default:              next_slverr = 1'b1;
            endcase
        end
        else if (PSEL_I)
            next_slverr = slverr;
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RESET_I)
        begin
            rdata  <= 32'h0000_0000;
            slverr <= 1'b0;
        end
        else
        begin
            rdata  <= next_rdata;
            slverr <= next_slverr;
        end
    end

    assign PRDATA_O           = rdata;
    assign PREADY_O           = 1'b1;
    assign PSLVERR_O          = slverr & PSEL_I & PENABLE_I;
    assign DEBUG_SERIAL_OUT_O = out_sr[16]; // [R24]
    assign WORD_READY_O       = rx_valid; // [R8]

    default clocking dflt_cb @(posedge REF_CLK_I); endclocking
    default disable iff (RESET_I);

    property p_sync;
        rise |-> $past(DEBUG_SERIAL_CLOCK_I, 2) && !$past(DEBUG_SERIAL_CLOCK_I, 3);
    endproperty
    a_sync: assert property (p_sync) else $error("edge not from synced clock"); // [R4]

    property p_shift_in;
        (state == dsc_pkg::ST_WAIT) && enable && rise
        |=> (bit_cnt == $past(bit_cnt) - 5'h1) && (in_sr[0] == $past(din_s2));
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift in or count wrong"); // [R5]

    property p_shift_out;
        (state == dsc_pkg::ST_STEP) && (bit_cnt != 5'h0)
        |=> out_sr == {$past(out_sr[15:0]), 1'b0};
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("output not advanced"); // [R6]

    property p_latch;
        (state == dsc_pkg::ST_STEP) && (bit_cnt == 5'h0)
        |=> rx_valid && (rx_word == $past(in_sr)) && (bit_cnt == dsc_pkg::BIT_CNT_INIT);
    endproperty
    a_latch: assert property (p_latch) else $error("word not latched"); // [R7]

    property p_not_ready;
        (state == dsc_pkg::ST_STEP) && (bit_cnt == 5'h0)
        |=> DEBUG_SERIAL_OUT_O && (out_sr == 17'h1_0000);
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("not ready not loaded"); // [R2]

    property p_apply;
        apply && !(apb_wr && (PADDR_I == dsc_pkg::ADDR_RESP))
        |=> (DEBUG_SERIAL_OUT_O == $past(pend_resp[16])) && !pend_valid;
    endproperty
    a_apply: assert property (p_apply) else $error("response not driven"); // [R9]

    property p_interlock;
        (bit_cnt != dsc_pkg::BIT_CNT_INIT) && (state == dsc_pkg::ST_WAIT) && !rise
        |=> $stable(out_sr);
    endproperty
    a_interlock: assert property (p_interlock) else $error("output changed mid transfer"); // [R11]

    property p_codes;
        apb_wr && (PADDR_I == dsc_pkg::ADDR_RESP) && (PWDATA_I[1:0] == 2'h2)
        |=> pend_valid && (pend_resp == 17'h1_0001);
    endproperty
    a_codes: assert property (p_codes) else $error("bus error code wrong"); // [R3]

    property p_complete;
        apb_wr && (PADDR_I == dsc_pkg::ADDR_RESP) && (PWDATA_I[1:0] == 2'h1)
        |=> pend_resp == 17'h0_FFFF;
    endproperty
    a_complete: assert property (p_complete) else $error("complete code wrong"); // [R1]

    property p_hold;
        rx_valid && !apb_rd_rx |=> rx_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("word ready dropped"); // [R8]

    property p_count;
        bit_cnt <= 5'h11;
    endproperty
    a_count: assert property (p_count) else $error("bit count out of range"); // [R23]

    property p_word_ready;
        $rose(rx_valid) |-> ($past(state) == dsc_pkg::ST_STEP) && ($past(bit_cnt) == 5'h0);
    endproperty
    a_word_ready: assert property (p_word_ready) else $error("word ready without latch"); // [R7]

    property p_illegal;
        apb_wr && (PADDR_I == dsc_pkg::ADDR_RESP) && (PWDATA_I[1:0] == 2'h3)
        |=> pend_valid && (pend_resp == 17'h1_FFFF);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal code wrong"); // [R3]

    property p_data_resp;
        apb_wr && (PADDR_I == dsc_pkg::ADDR_RESP) && (PWDATA_I[1:0] == 2'h0)
        |=> pend_resp == {1'b0, $past(PWDATA_I[31:16])};
    endproperty
    a_data_resp: assert property (p_data_resp) else $error("data response wrong"); // [R1]

    property p_refused;
        !enable && (state == dsc_pkg::ST_WAIT) |=> bit_cnt == dsc_pkg::BIT_CNT_INIT;
    endproperty
    a_refused: assert property (p_refused) else $error("disabled port counted"); // [R5]
endmodule // dsc_port
`default_nettype wire

/* test/dsc_master.sv */
// Serial master model of the development system on the debug link
`default_nettype none
module dsc_master (
    output logic      ser_clk_o,
    output logic      ser_data_o,
    input  wire logic ser_data_i
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 100;

    initial
    begin
        // Shared request line stays high: no breakpoint is forced here
        ser_clk_o = 1'b1;
        ser_data_o = 1'b1;
    end

    // Odd start offset keeps link edges off the system clock edges
    task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
        #7;
        for (int i = 16; i >= 0; i--)
        begin
            ser_clk_o = 1'b0;
            #(HALF / 4);
            ser_data_o = tx[i];
            #(HALF * 3 / 4);
            ser_clk_o = 1'b1;
            rx[i] = ser_data_i;
            #HALF;
        end
        // Stale data would hide a sampling slip
        ser_data_o = ~tx[0];
    endtask

    // Bounded wait so a stuck status line cannot hang the master
    task automatic wait_change(output logic moved);
        logic start;
        start = ser_data_i;
        moved = 1'b0;
        for (int t = 0; t < 200 && moved == 1'b0; t++)
        begin
            #10;
            moved = (ser_data_i !== start);
        end
    endtask
endmodule // dsc_master
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the debug serial command port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, psel, pen, pwr, pready, pslverr, sclk, sdi, sdo, wrdy, err, moved;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [16:0] tx, rx, exp_rx;
    logic [15:0] data;
    logic [1:0]  kind;
    int          errors, checked, cycles, seed;

    dsc_port i_dsc_port (
        .REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .DEBUG_SERIAL_CLOCK_I(sclk),
        .DEBUG_SERIAL_IN_I(sdi), .DEBUG_SERIAL_OUT_O(sdo), .WORD_READY_O(wrdy));
    dsc_master i_dsc_master (.ser_clk_o(sclk), .ser_data_o(sdi), .ser_data_i(sdo));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end

    task automatic results();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    function automatic logic [16:0] resp_word(input logic [1:0] k, input logic [15:0] d);
        case (k)
            2'h0: resp_word = {1'b0, d};
            2'h1: resp_word = 17'h0_FFFF;
            2'h2: resp_word = 17'h1_0001;
            default: resp_word = 17'h1_FFFF;
        endcase
    endfunction

    function automatic logic [31:0] decode(input logic [16:0] w);
        decode = 32'h0000_0000;
        decode[5:0] = w[15:10];
        decode[8] = w[8];
        decode[10:9] = w[7:6];
        decode[12] = w[3];
        decode[15:13] = w[2:0];
        decode[16] = w[9] | w[5] | w[4] | (w[7:6] == 2'h3);
        decode[18:17] = (w[7:6] == 2'h2) ? 2'h2 : 2'h1;
    endfunction

    // Checks one finished frame, then reads it back as software would
    task automatic post();
        int n;
        n = 0;
        check(rx, exp_rx);
        while (wrdy !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        check({wrdy, sdo}, 2'h3);
        apb(1'b0, dsc_pkg::ADDR_RX, 32'h0000_0000);
        check(rd, {15'h0000, tx});
        repeat (2) @(posedge clk);
        check(wrdy, 1'b0);
        apb(1'b0, dsc_pkg::ADDR_CMD, 32'h0000_0000);
        check(rd, decode(tx));
    endtask

    initial
    begin
        seed = 17143;
        {rst, psel, pen, pwr} = 4'h8;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check({wrdy, sdo}, 2'h1);
        apb(1'b0, dsc_pkg::ADDR_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0110);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check({rd[30:0], err}, 32'h0000_0001);
        $display("reset and register map test done");
        exp_rx = 17'h1_0000;
        for (int n = 0; n < 16; n++)
        begin
            tx = {1'b0, 16'($random(seed))};
            if (n == 6)
                tx = 17'h0_FFFF;
            i_dsc_master.xfer(tx, rx);
            post();
            // Every fifth command gets no answer, so not ready must repeat
            if (n % 5 == 4)
                exp_rx = 17'h1_0000;
            else
            begin
                kind = 2'(n);
                data = 16'($random(seed));
                apb(1'b1, dsc_pkg::ADDR_RESP, {data, 14'h0000, kind});
                exp_rx = resp_word(kind, data);
                if (kind < 2'h2)
                begin
                    i_dsc_master.wait_change(moved);
                    check(moved, 1'b1);
                end
                repeat (2) @(posedge clk);
                check(sdo, exp_rx[16]);
            end
        end
        $display("response kinds test done");
        // Disabled port ignores a whole frame and leaves its output frozen
        apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h0000_0000);
        i_dsc_master.xfer(tx, rx);
        check(rx, {17{exp_rx[16]}});
        apb(1'b0, dsc_pkg::ADDR_STATUS, 32'h0000_0000);
        check(rd, 32'h0000_0110);
        apb(1'b1, dsc_pkg::ADDR_CTRL, 32'h0000_0001);
        apb(1'b0, dsc_pkg::ADDR_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0001);
        tx = {1'b0, 16'($random(seed))};
        fork
            i_dsc_master.xfer(tx, rx);
            begin
                #1700;
                apb(1'b1, dsc_pkg::ADDR_RESP, 32'h0000_0001);
                apb(1'b0, dsc_pkg::ADDR_STATUS, 32'h0000_0000);
                check(rd[2:1], 2'h3);
            end
        join
        post();
        exp_rx = 17'h0_FFFF;
        tx = 17'h0_2180;
        i_dsc_master.xfer(tx, rx);
        post();
        $display("mid-frame response test done");
        results();
    end
endmodule // tb_top
`default_nettype wire
